// ---- core/slhm_monitor.sv ----
/*
  Soft position limit and home switch monitor. Holds the four parameters,
  compares the commanded position against the active limits, requests a
  quick stop and latches a class 1 error. Assumes the motion core drives
  the motion carrier on mclk_in and executes the quick stop itself.
*/
`timescale 1ns/1ps
module slhm_monitor #(
  parameter int POS_W = 32,
  parameter logic signed [31:0] USR_MAX = 32'sh7FFFFFFF,
  parameter logic signed [31:0] USR_MIN = 32'sh80000000
) (
  // Clock, reset, enable.
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  // Parameter port.
  input wire slhm_pkg::slhm_req_t req_in,
  output slhm_pkg::slhm_rsp_t rsp_out,
  // Drive state.
  input wire slhm_pkg::slhm_motion_t motion_in,
  input wire logic power_enabled_in,
  input wire logic zero_valid_in,
  input wire logic fault_reset_in,
  input wire logic [1:0] quick_stop_response_select_in,
  // Home switch pin.
  input wire logic home_switch_pin_in,
  // Results.
  output logic home_detect_out,
  output logic quick_stop_req_out,
  output logic [1:0] quick_stop_response_out,
  output logic error_class1_out,
  output logic move_refused_out,
  output logic pos_violation_out,
  output logic neg_violation_out
);

  // Only full 32 bit positions and an ordered user range are served.
  if (POS_W != 32 || USR_MIN > USR_MAX) begin : g_param_check
    $error("slhm_monitor needs 32 bit positions and USR_MIN <= USR_MAX");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parameter storage: written copies and active copies.

  logic [1:0] enable_ff;
  logic signed [31:0] pos_lim_ff;
  logic signed [31:0] neg_lim_ff;
  logic [15:0] pol_ff;
  logic signed [31:0] pos_lim_act_ff;
  logic signed [31:0] neg_lim_act_ff;
  logic [15:0] pol_act_ff;
  logic power_prev_ff;
  slhm_pkg::slhm_rsp_t nxt_rsp;
  slhm_pkg::slhm_lim_state_t lim_ff;
  slhm_pkg::slhm_lim_state_t nxt_lim;

  wire is_en = req_in.addr == slhm_pkg::ADDR_ENABLE;
  wire is_pos = req_in.addr == slhm_pkg::ADDR_POS_LIMIT;
  wire is_neg = req_in.addr == slhm_pkg::ADDR_NEG_LIMIT;
  wire is_pol = req_in.addr == slhm_pkg::ADDR_HOME_POL;
  wire mapped = is_en | is_pos | is_neg | is_pol;
  wire locked_reg = is_pos | is_neg | is_pol;
  // RULE_04 power lock
  wire wr_locked = req_in.wr & locked_reg & power_enabled_in;
  // RULE_02 polarity decode
  wire pol_ok = req_in.wdata[31:16] == 16'h0000 &&
    (req_in.wdata[15:0] == slhm_pkg::POL_NC ||
    req_in.wdata[15:0] == slhm_pkg::POL_NO);
  // RULE_14 enable decode
  wire en_code_ok = req_in.wdata[31:16] == 16'h0000 &&
    req_in.wdata[15:0] <= slhm_pkg::ENABLE_MAX;
  // RULE_10 zero point gate
  wire en_ok = en_code_ok &&
    (req_in.wdata[1:0] == slhm_pkg::ENABLE_RESET || zero_valid_in);
  wire signed [31:0] wval = req_in.wdata;
  // RULE_16 range clamp
  wire lim_out_range = wval > USR_MAX || wval < USR_MIN;
  wire signed [31:0] lim_val = lim_out_range ? USR_MAX : wval;
  wire range_bad = (is_en & ~en_ok) | (is_pol & ~pol_ok);
  wire wr_go = req_in.wr & mapped & ~wr_locked & ~range_bad;
  wire power_rise = power_enabled_in & ~power_prev_ff;

  always_comb begin
    nxt_rsp = '0;
    nxt_rsp.ack = req_in.wr | req_in.rd;
    if (!mapped) begin
      nxt_rsp.code = slhm_pkg::ACK_UNMAPPED;
    end else if (wr_locked) begin
      nxt_rsp.code = slhm_pkg::ACK_LOCKED;
    end else if (req_in.wr && range_bad) begin
      nxt_rsp.code = slhm_pkg::ACK_RANGE;
    end else begin
      nxt_rsp.code = slhm_pkg::ACK_OK;
    end
    if (req_in.rd && is_en) begin
      nxt_rsp.rdata = {30'h0, enable_ff};
    end else if (req_in.rd && is_pos) begin
      nxt_rsp.rdata = pos_lim_ff;
    end else if (req_in.rd && is_neg) begin
      nxt_rsp.rdata = neg_lim_ff;
    end else if (req_in.rd && is_pol) begin
      nxt_rsp.rdata = {16'h0, pol_ff};
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      rsp_out <= '0;
    end else if (clk_en_in) begin
      rsp_out <= nxt_rsp;
    end
  end

  // Previous power level, so a power stage enable is seen as one edge.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      power_prev_ff <= 1'b0;
    end else if (clk_en_in) begin
      power_prev_ff <= power_enabled_in;
    end
  end

  // RULE_15 immediate enable
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      enable_ff <= slhm_pkg::ENABLE_RESET;
    end else if (clk_en_in && wr_go && is_en) begin
      enable_ff <= req_in.wdata[1:0];
    end
  end

  // RULE_17 signed defaults
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pos_lim_ff <= slhm_pkg::POS_LIMIT_RESET;
    end else if (clk_en_in && wr_go && is_pos) begin
      pos_lim_ff <= lim_val;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      neg_lim_ff <= slhm_pkg::NEG_LIMIT_RESET;
    end else if (clk_en_in && wr_go && is_neg) begin
      neg_lim_ff <= lim_val;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pol_ff <= slhm_pkg::POL_NC;
    end else if (clk_en_in && wr_go && is_pol) begin
      pol_ff <= req_in.wdata[15:0];
    end
  end

  // RULE_04 apply at enable
  // Copies are taken only on the enable edge, so a value written while the
  // stage was off never changes the limits under a running axis.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pos_lim_act_ff <= slhm_pkg::POS_LIMIT_RESET;
    end else if (clk_en_in && power_rise) begin
      pos_lim_act_ff <= pos_lim_ff;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      neg_lim_act_ff <= slhm_pkg::NEG_LIMIT_RESET;
    end else if (clk_en_in && power_rise) begin
      neg_lim_act_ff <= neg_lim_ff;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pol_act_ff <= slhm_pkg::POL_NC;
    end else if (clk_en_in && power_rise) begin
      pol_act_ff <= pol_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Home switch. The pin is asynchronous, so it is synchronised first.

  logic home_meta_ff;
  logic home_sync_ff;

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      home_meta_ff <= 1'b0;
      home_sync_ff <= 1'b0;
    end else if (clk_en_in) begin
      home_meta_ff <= home_switch_pin_in;
      home_sync_ff <= home_meta_ff;
    end
  end

  // RULE_02 contact sense
  wire home_level = pol_act_ff == slhm_pkg::POL_NC ?
    ~home_sync_ff : home_sync_ff;
  // RULE_01 homing only
  // RULE_03 reference move
  wire home_live = motion_in.mode == slhm_pkg::MODE_HOMING &&
    motion_in.moving;

  ////////////////////////////////////////////////////////////////////////////
  // Limit comparison on the reference position.

  // RULE_14 enable bits
  // RULE_15 immediate enable
  wire positive_soft_limit_on = enable_ff[slhm_pkg::ENABLE_POS_BIT];
  wire negative_soft_limit_on = enable_ff[slhm_pkg::ENABLE_NEG_BIT];
  // RULE_09 zero point gate
  wire pos_arm = positive_soft_limit_on & zero_valid_in;
  wire neg_arm = negative_soft_limit_on & zero_valid_in;
  // RULE_08 reference position
  // RULE_20 inclusive compare
  wire pos_hit = pos_arm && motion_in.ref_pos >= pos_lim_act_ff;
  wire neg_hit = neg_arm && motion_in.ref_pos <= neg_lim_act_ff;

  wire mode_step = motion_in.mode == slhm_pkg::MODE_JOG_STEP ||
    motion_in.mode == slhm_pkg::MODE_PROFILE_POS;
  // RULE_12 target precheck
  wire tgt_pos_bad = pos_arm && motion_in.target_pos > pos_lim_act_ff;
  wire tgt_neg_bad = neg_arm && motion_in.target_pos < neg_lim_act_ff;
  wire start_refused = motion_in.move_start && mode_step &&
    (tgt_pos_bad || tgt_neg_bad);

  // RULE_07 toward violated limit
  wire toward_bad = motion_in.move_start &&
    ((lim_ff == slhm_pkg::LIM_POS_HIT && motion_in.dir_pos) ||
    (lim_ff == slhm_pkg::LIM_NEG_HIT && !motion_in.dir_pos));
  // RULE_11 halt at limit
  // RULE_13 stop at limit
  wire hit_pos_move = pos_hit && motion_in.moving && motion_in.dir_pos;
  wire hit_neg_move = neg_hit && motion_in.moving && !motion_in.dir_pos;
  wire new_event = hit_pos_move | hit_neg_move | toward_bad;

  always_comb begin
    nxt_lim = lim_ff;
    case (lim_ff)
      slhm_pkg::LIM_IDLE: begin
        if (hit_pos_move) begin
          nxt_lim = slhm_pkg::LIM_POS_HIT;
        end else if (hit_neg_move) begin
          nxt_lim = slhm_pkg::LIM_NEG_HIT;
        end
      end
      slhm_pkg::LIM_POS_HIT: begin
        if (!pos_hit) begin
          nxt_lim = slhm_pkg::LIM_IDLE;
        end
      end
      slhm_pkg::LIM_NEG_HIT: begin
        if (!neg_hit) begin
          nxt_lim = slhm_pkg::LIM_IDLE;
        end
      end
      default: begin
        nxt_lim = slhm_pkg::LIM_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      lim_ff <= slhm_pkg::LIM_IDLE;
    end else if (clk_en_in) begin
      lim_ff <= nxt_lim;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      home_detect_out <= 1'b0;
    end else if (clk_en_in) begin
      home_detect_out <= home_live & home_level;
    end
  end

  // RULE_05 quick stop
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      quick_stop_req_out <= 1'b0;
    end else if (clk_en_in) begin
      quick_stop_req_out <= new_event;
    end
  end

  // RULE_19 stop response
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      quick_stop_response_out <= 2'h0;
    end else if (clk_en_in) begin
      quick_stop_response_out <= quick_stop_response_select_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      move_refused_out <= 1'b0;
    end else if (clk_en_in) begin
      move_refused_out <= start_refused | toward_bad;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pos_violation_out <= 1'b0;
    end else if (clk_en_in) begin
      pos_violation_out <= pos_hit;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      neg_violation_out <= 1'b0;
    end else if (clk_en_in) begin
      neg_violation_out <= neg_hit;
    end
  end

  // RULE_06 fault reset
  // A new event in the reset cycle wins so it is never lost.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      error_class1_out <= 1'b0;
    end else if (clk_en_in && new_event) begin
      error_class1_out <= 1'b1;
    end else if (clk_en_in && fault_reset_in) begin
      error_class1_out <= 1'b0;
    end
  end

endmodule

// ---- shared/slhm_pkg.sv ----
/*
  Constants, register map and carrier types of the soft limit and home
  switch monitor. Assumes a parameter port addressed by the printed
  parameter offsets; word index times four is not used because the port
  is the documented parameter address, not a byte bus.
*/
// How it works
// RULE_01: Home switch is evaluated only in the homing operating mode.
// RULE_02: Polarity 1 means normally closed, 2 normally open; other values refused.
// RULE_03: Home switch is live only during a reference move toward it; code gates on homing and moving in either direction.
// RULE_04: Polarity and limits refused while powered; take effect at next enable.
// RULE_05: Triggered enabled limit causes a quick stop and a class 1 error.
// RULE_06: Fault reset clears the limit-violation error.
// RULE_07: After a trigger only motion away is allowed; toward raises new error.
// RULE_08: Limits compare the reference position, not the actual position.
// RULE_09: No limit comparison without a valid zero point.
// RULE_10: Enabling a soft limit is refused while the zero point is invalid.
// RULE_11: Target modes start beyond-limit moves, then quick stop at the limit; code refuses such starts in step jog and profile position.
// RULE_12: Step jog and profile position check the target before starting.
// RULE_13: Modes without target quick stop when position reaches a limit.
// RULE_14: Enable setting: 0 off, 1 positive, 2 negative, 3 both.
// RULE_15: Limit enable changes take effect immediately.
// RULE_16: Out-of-range written limit is replaced by the maximum user value.
// RULE_17: Limits are signed 32 bit; defaults are max and min integer.
// RULE_18: Controller assigns the home switch function to an input first.
// RULE_19: Limit quick stop follows the quick stop response setting.
// RULE_20: Positive violation at or above limit; negative at or below.
package slhm_pkg;

  localparam logic [11:0] ADDR_ENABLE = 12'h606;
  localparam logic [11:0] ADDR_POS_LIMIT = 12'h608;
  localparam logic [11:0] ADDR_NEG_LIMIT = 12'h60A;
  localparam logic [11:0] ADDR_HOME_POL = 12'h61C;

  localparam logic [1:0] ENABLE_RESET = 2'h0;
  localparam logic signed [31:0] POS_LIMIT_RESET = 32'sh7FFFFFFF;
  localparam logic signed [31:0] NEG_LIMIT_RESET = 32'sh80000000;
  localparam logic [15:0] POL_NC = 16'h0001;
  localparam logic [15:0] POL_NO = 16'h0002;
  localparam logic [15:0] ENABLE_MAX = 16'h0003;
  localparam int ENABLE_POS_BIT = 0;
  localparam int ENABLE_NEG_BIT = 1;

  // Operating mode codes presented by the mode selector.
  localparam logic [2:0] MODE_HOMING = 3'h1;
  localparam logic [2:0] MODE_JOG_STEP = 3'h2;
  localparam logic [2:0] MODE_JOG_CONT = 3'h3;
  localparam logic [2:0] MODE_PROFILE_POS = 3'h4;
  localparam logic [2:0] MODE_SPEED = 3'h5;
  localparam logic [2:0] MODE_PROFILE_VEL = 3'h6;

  // Answer codes of the parameter port.
  localparam logic [1:0] ACK_OK = 2'h0;
  localparam logic [1:0] ACK_LOCKED = 2'h1;
  localparam logic [1:0] ACK_RANGE = 2'h2;
  localparam logic [1:0] ACK_UNMAPPED = 2'h3;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } slhm_req_t;

  typedef struct packed {
    logic ack;
    logic [1:0] code;
    logic [31:0] rdata;
  } slhm_rsp_t;

  typedef struct packed {
    logic [2:0] mode;
    logic signed [31:0] ref_pos;
    logic signed [31:0] target_pos;
    logic move_start;
    logic dir_pos;
    logic moving;
  } slhm_motion_t;

  typedef enum logic [2:0] {
    LIM_IDLE = 3'b001,
    LIM_POS_HIT = 3'b010,
    LIM_NEG_HIT = 3'b100
  } slhm_lim_state_t;

endpackage

// ---- dv/slhm_plc.sv ----
/* Parameter master model that presents one request per go cycle.
   Assumes the bench raises go_in just after a rising clock edge. */
`timescale 1ns/1ps
module slhm_plc (
  // Clock.
  input wire logic mclk_in,
  // Bench command.
  input wire logic go_in,
  input wire slhm_pkg::slhm_req_t cmd_in,
  // Parameter port.
  output slhm_pkg::slhm_req_t req_out
);
  //////////////////////////////////////////////////////////////////////
  // Idle address and data are inverted so stale values never look valid.
  initial req_out = '0;
  always @(posedge mclk_in) begin
    req_out <= #1 go_in ? cmd_in : {2'h0, ~cmd_in[43:0]};
  end
endmodule

// ---- dv/slhm_monitor_chk.sv ----
/* Assertion checker for the limit monitor, bound to its ports.
   Assumes clk_en_in stays high while motion results are judged. */
`timescale 1ns/1ps
module slhm_monitor_chk (
  // Clock and control.
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  // Parameter port.
  input wire slhm_pkg::slhm_req_t req_in,
  input wire slhm_pkg::slhm_rsp_t rsp_out,
  // Drive state.
  input wire slhm_pkg::slhm_motion_t motion_in,
  input wire logic power_enabled_in,
  input wire logic zero_valid_in,
  input wire logic fault_reset_in,
  input wire logic [1:0] quick_stop_response_select_in,
  input wire logic home_switch_pin_in,
  // Results.
  input wire logic home_detect_out,
  input wire logic quick_stop_req_out,
  input wire logic [1:0] quick_stop_response_out,
  input wire logic error_class1_out,
  input wire logic move_refused_out,
  input wire logic pos_violation_out,
  input wire logic neg_violation_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  //////////////////////////////////////////////////////////////////////
  wire logic wr = clk_en_in && req_in.wr;
  wire logic tk = wr || (clk_en_in && req_in.rd);
  wire logic lk = req_in.addr inside {slhm_pkg::ADDR_POS_LIMIT,
    slhm_pkg::ADDR_NEG_LIMIT, slhm_pkg::ADDR_HOME_POL};
  wire logic en = wr && req_in.addr == slhm_pkg::ADDR_ENABLE;
  wire logic pw = wr && req_in.addr == slhm_pkg::ADDR_HOME_POL;
  a_ack_latency: assert property (tk |=> rsp_out.ack)
    else $error("no answer one cycle after request");
  a_locked_write: assert property (wr && lk && power_enabled_in
    |=> rsp_out.code == slhm_pkg::ACK_LOCKED)
    else $error("write while powered not locked");
  a_enable_zero: assert property (en && req_in.wdata != 0
    && !zero_valid_in |=> rsp_out.code == slhm_pkg::ACK_RANGE)
    else $error("enable accepted without zero point");
  a_pol_values: assert property (pw && !power_enabled_in
    && !(req_in.wdata inside {1, 2}) |=> rsp_out.code == slhm_pkg::ACK_RANGE)
    else $error("bad polarity accepted");
  a_stop_error: assert property (quick_stop_req_out |-> error_class1_out)
    else $error("stop without error");
  a_stop_response: assert property ($past(clk_en_in) && quick_stop_req_out
    |-> quick_stop_response_out == $past(quick_stop_response_select_in))
    else $error("stop response not followed");
  a_error_sticky: assert property (error_class1_out && !fault_reset_in
    && clk_en_in |=> error_class1_out)
    else $error("error lost without fault reset");
  a_home_gate: assert property (home_detect_out |->
    $past(motion_in.mode) == slhm_pkg::MODE_HOMING && $past(motion_in.moving))
    else $error("home switch live outside homing move");
  a_refuse_cause: assert property (move_refused_out
    |-> $past(motion_in.move_start))
    else $error("refusal without start");
  a_zero_gate: assert property ($past(clk_en_in && !zero_valid_in)
    |-> !pos_violation_out && !neg_violation_out)
    else $error("violation without zero point");
  c_stop: cover property (quick_stop_req_out);
  c_refuse: cover property (move_refused_out);
  c_home: cover property (home_detect_out);
endmodule
bind slhm_monitor slhm_monitor_chk slhm_monitor_chk_inst (.*);

// ---- dv/slhm_monitor_tb.sv ----
/* Self-checking bench for the limit monitor with a parameter master.
   Assumes answers come one cycle after the master presents a request. */
`timescale 1ns/1ps
module slhm_monitor_tb;
  localparam logic signed [31:0] UMAX = 32'sh000F4240;
  logic mclk_in = 0, sys_rst_in = 1, go = 0, pwr = 0, zv = 0, frst = 0;
  logic pin = 0, cke = 1, hd, qs, er, rf, pv, nv;
  logic [1:0] qr;
  logic [1:0] qsel = 2'h2;
  logic [33:0] expq[$];
  slhm_pkg::slhm_req_t cmd = '0, req;
  slhm_pkg::slhm_rsp_t rsp;
  slhm_pkg::slhm_motion_t mo = '0;
  int fail_count = 0, tests_run = 0, seed = 2, i;
  always #5 mclk_in = ~mclk_in;
  slhm_plc slhm_plc_inst (.mclk_in(mclk_in), .go_in(go), .cmd_in(cmd),
    .req_out(req));
  // A narrowed user range lets the clamp of out-of-range limits be seen.
  slhm_monitor #(.USR_MAX(UMAX), .USR_MIN(-UMAX)) slhm_monitor_inst (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .clk_en_in(cke), .req_in(req), .rsp_out(rsp), .motion_in(mo),
    .power_enabled_in(pwr), .zero_valid_in(zv), .fault_reset_in(frst),
    .quick_stop_response_select_in(qsel), .home_switch_pin_in(pin),
    .home_detect_out(hd), .quick_stop_req_out(qs),
    .quick_stop_response_out(qr), .error_class1_out(er),
    .move_refused_out(rf), .pos_violation_out(pv), .neg_violation_out(nv));
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic idle(input int n);
    go = 0;
    cyc(n);
  endtask
  task automatic st(input logic [4:0] e);
    chk(34'({qs, er, pv, nv, rf}), 34'(e));
  endtask
  task automatic endt(input string s);
    $display("test %s done, mismatches %0d", s, fail_count);
  endtask
  // The go line stays high across back-to-back calls; idle drops it.
  task automatic acc(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [1:0] c, input logic [31:0] r);
    cmd = '{wr: w, rd: !w, addr: a, wdata: d};
    go = 1;
    expq.push_back({c, r});
    cyc(1);
  endtask
  always @(posedge mclk_in) begin
    if (rsp.ack === 1'b1) begin
      chk({rsp.code, rsp.rdata}, expq.size() ? expq.pop_front() : 34'h3FFFFFFFF);
    end
  end
  initial begin
    #100000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    cyc(2);
    sys_rst_in = 0;
    acc(0, slhm_pkg::ADDR_ENABLE, 0, slhm_pkg::ACK_OK, 0);
    acc(0, slhm_pkg::ADDR_POS_LIMIT, 0, slhm_pkg::ACK_OK, 32'h7FFFFFFF);
    acc(0, slhm_pkg::ADDR_NEG_LIMIT, 0, slhm_pkg::ACK_OK, 32'h80000000);
    acc(0, slhm_pkg::ADDR_HOME_POL, 0, slhm_pkg::ACK_OK, 32'h1);
    acc(0, 12'h600, 0, slhm_pkg::ACK_UNMAPPED, 0);
    acc(1, slhm_pkg::ADDR_HOME_POL, 32'h3, slhm_pkg::ACK_RANGE, 0);
    acc(1, slhm_pkg::ADDR_HOME_POL, 32'h0, slhm_pkg::ACK_RANGE, 0);
    acc(1, slhm_pkg::ADDR_HOME_POL, 32'h2, slhm_pkg::ACK_OK, 0);
    acc(1, slhm_pkg::ADDR_ENABLE, 32'h1, slhm_pkg::ACK_RANGE, 0);
    idle(2);
    zv = 1;
    acc(1, slhm_pkg::ADDR_ENABLE, 32'h4, slhm_pkg::ACK_RANGE, 0);
    acc(1, slhm_pkg::ADDR_POS_LIMIT, 32'h7FFFFFFF, slhm_pkg::ACK_OK,
      0);
    acc(0, slhm_pkg::ADDR_POS_LIMIT, 0, slhm_pkg::ACK_OK, UMAX);
    acc(1, slhm_pkg::ADDR_POS_LIMIT, 32'h64, slhm_pkg::ACK_OK, 0);
    acc(1, slhm_pkg::ADDR_NEG_LIMIT, 32'hFFFFFF9C, slhm_pkg::ACK_OK, 0);
    acc(0, slhm_pkg::ADDR_POS_LIMIT, 0, slhm_pkg::ACK_OK, 32'h64);
    idle(2);
    pwr = 1;
    idle(2);
    acc(1, slhm_pkg::ADDR_POS_LIMIT, 32'h5, slhm_pkg::ACK_LOCKED, 0);
    acc(1, slhm_pkg::ADDR_ENABLE, 32'h1, slhm_pkg::ACK_OK, 0);
    idle(3);
    endt("params");
    mo.mode = slhm_pkg::MODE_SPEED;
    mo.moving = 1;
    mo.dir_pos = 1;
    for (i = 0; i < 4; i++) begin
      mo.ref_pos = $random(seed) % 32'sh64;
      cyc(1);
      st(5'h00);
    end
    mo.ref_pos = 32'h64;
    qsel = 2'($random(seed));
    cyc(1);
    st(5'h1C);
    chk(34'(qr), 34'(qsel));
    mo.dir_pos = 0;
    mo.ref_pos = 32'h32;
    cyc(1);
    st(5'h08);
    frst = 1;
    cyc(1);
    frst = 0;
    cyc(1);
    st(5'h00);
    mo.dir_pos = 1;
    mo.ref_pos = 32'h78;
    cyc(1);
    st(5'h1C);
    mo.moving = 0;
    mo.move_start = 1;
    cyc(1);
    st(5'h1D);
    mo.dir_pos = 0;
    cyc(1);
    st(5'h0C);
    mo.move_start = 0;
    mo.moving = 1;
    mo.dir_pos = 1;
    zv = 0;
    cyc(1);
    st(5'h08);
    zv = 1;
    mo.dir_pos = 0;
    mo.ref_pos = 32'hFFFFFF6A;
    frst = 1;
    cyc(1);
    frst = 0;
    cyc(1);
    st(5'h00);
    // With the clock enable low a crossing must leave the stop, error, violation and refusal outputs frozen.
    cke = 0;
    mo.ref_pos = 32'h78;
    mo.dir_pos = 1;
    cyc(2);
    st(5'h00);
    cke = 1;
    mo.ref_pos = 32'hFFFFFF6A;
    mo.dir_pos = 0;
    acc(1, slhm_pkg::ADDR_ENABLE, 32'h3, slhm_pkg::ACK_OK, 0);
    idle(2);
    st(5'h1A);
    endt("limits");
    mo.mode = slhm_pkg::MODE_PROFILE_POS;
    mo.ref_pos = 0;
    mo.dir_pos = 1;
    mo.target_pos = 32'h1F4;
    mo.move_start = 1;
    frst = 1;
    // The switch input is wired and driven before homing relies on it.
    pin = 1;
    cyc(1);
    chk(34'(rf), 34'h1);
    mo.move_start = 0;
    frst = 0;
    cyc(3);
    chk(34'(hd), 34'h0);
    mo.mode = slhm_pkg::MODE_HOMING;
    i = 0;
    while (hd !== 1'b1 && i < 8) begin
      cyc(1);
      i++;
    end
    chk(34'(hd), 34'h1);
    if (i >= 8) report_and_stop();
    mo.moving = 0;
    cyc(2);
    chk(34'(hd), 34'h0);
    endt("motion");
    idle(3);
    chk(34'(expq.size()), 34'h0);
    report_and_stop();
  end
endmodule
